//--- hdl/sodt_pkg.sv
// Function
// - Open mode select: non-retriggerable off-delay on deassert
// - Non-retriggerable off-delay runs full duration unless a config strobe aborts it
// - Off-delay modes: link asserts, outputs on promptly
// - Off-delay modes: timer expiry switches outputs off
// - Non-retriggerable reassert while timing: recoverable fault
// - Fault clears shortly after link deasserts post-expiry
// - Deassert during timing: fault clears at expiry
// - Strap to companion terminal selects retriggerable
// - Retriggerable reassert resets timer, outputs stay on
// - On-delay: outputs on after delay from assert
// - On-delay: outputs held until link deasserts
// - On-delay: early deassert cancels timing, outputs never switch on
// - Activity indicator flashes while any timer runs
// - On-delay early deassert zeroes timer, no fault
package sodt_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   // Times in ms
   localparam int unsigned FAULT_CLR_MS = 50;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned RED_HALF_MS = 150;
   localparam int unsigned FAULT_CLR_CYC = FAULT_CLR_MS * CYC_PER_MS;
   localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
   localparam int unsigned RED_HALF_CYC = RED_HALF_MS * CYC_PER_MS;
   localparam int unsigned RED_FLASHES = 4;
   localparam int unsigned RED_PAUSE_SLOTS = 6;
   localparam int unsigned DELAY_W = 32;
   localparam logic [DELAY_W-1:0] DELAY_RST = 32'h0000_0001;

   typedef enum logic [1:0] {
      SODT_MODE_OFF_NRT = 2'h0,
      SODT_MODE_OFF_RT = 2'h1,
      SODT_MODE_ON_DLY = 2'h2
   } sodt_mode_e;

   typedef enum logic [3:0] {
      SODT_ST_IDLE = 4'h1,
      SODT_ST_ON = 4'h2,
      SODT_ST_OFF_RUN = 4'h4,
      SODT_ST_ON_RUN = 4'h8
   } sodt_state_e;

   typedef struct packed {
      sodt_mode_e mode;
      logic [DELAY_W-1:0] delay;
      logic valid;
   } sodt_cfg_s;

   typedef struct packed {
      logic outputs_on;
      logic timing;
      logic fault;
   } sodt_status_s;
endpackage

//--- hdl/sodt_indicator.sv
`timescale 1ns/10ps
module sodt_indicator #(
   parameter int unsigned FLASH_HALF_CYC = sodt_pkg::FLASH_HALF_CYC,
   parameter int unsigned RED_HALF_CYC = sodt_pkg::RED_HALF_CYC,
   parameter int unsigned RED_FLASHES = sodt_pkg::RED_FLASHES,
   parameter int unsigned RED_PAUSE_SLOTS = sodt_pkg::RED_PAUSE_SLOTS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_i,
   input wire sodt_pkg::sodt_status_s status_i,
   output logic logic_in_led_o,
   output logic green_o,
   output logic red_o
);
   localparam int unsigned FW = $clog2(FLASH_HALF_CYC + 1);
   localparam int unsigned RW = $clog2(RED_HALF_CYC + 1);
   localparam int unsigned STEPS = 2 * RED_FLASHES + RED_PAUSE_SLOTS;
   localparam int unsigned SW = $clog2(STEPS + 1);

   logic [FW-1:0] flash_cnt_q;
   logic flash_q;
   logic [RW-1:0] red_cnt_q;
   logic [SW-1:0] step_q;
   wire flash_wrap = (flash_cnt_q == FW'(FLASH_HALF_CYC - 1));
   wire red_wrap = (red_cnt_q == RW'(RED_HALF_CYC - 1));
   wire step_last = (step_q == SW'(STEPS - 1));
   wire red_lit = status_i.fault && (step_q < SW'(2 * RED_FLASHES)) && !step_q[0];

   always_ff @(posedge clk_i) begin
      if (rst_i || !status_i.timing) begin
         flash_cnt_q <= '0;
         flash_q <= 1'b1;
      end else begin
         flash_cnt_q <= flash_wrap ? '0 : flash_cnt_q + 1'b1;
         if (flash_wrap) begin
            flash_q <= !flash_q;
         end
      end
   end

   // Burst of red flashes, then a dark pause, repeated
   always_ff @(posedge clk_i) begin
      if (rst_i || !status_i.fault) begin
         red_cnt_q <= '0;
         step_q <= '0;
      end else begin
         red_cnt_q <= red_wrap ? '0 : red_cnt_q + 1'b1;
         if (red_wrap) begin
            step_q <= step_last ? '0 : step_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         logic_in_led_o <= 1'b0;
         green_o <= 1'b0;
         red_o <= 1'b0;
      end else begin
         logic_in_led_o <= status_i.timing ? flash_q : link_i;
         green_o <= 1'b1;
         red_o <= red_lit;
      end
   end
endmodule // sodt_indicator

//--- hdl/sodt_timer.sv
`timescale 1ns/10ps
module sodt_timer #(
   parameter int unsigned DELAY_W = sodt_pkg::DELAY_W,
   parameter int unsigned FAULT_CLR_CYC = sodt_pkg::FAULT_CLR_CYC,
   parameter int unsigned FLASH_HALF_CYC = sodt_pkg::FLASH_HALF_CYC,
   parameter int unsigned RED_HALF_CYC = sodt_pkg::RED_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic logic_link_input_i,
   input wire logic mode_select_input_i,
   input wire logic on_delay_select_i,
   input wire logic config_i,
   input wire logic [DELAY_W-1:0] delay_setting_i,
   output logic safety_out_o,
   output logic timing_o,
   output logic fault_o,
   output logic configured_o,
   output sodt_pkg::sodt_mode_e mode_o,
   output logic logic_in_led_o,
   output logic power_fault_green_o,
   output logic power_fault_red_o
);
   localparam int unsigned CW = $clog2(FAULT_CLR_CYC + 1);

   function automatic logic sodt_reached(input logic [DELAY_W-1:0] cnt, input logic [DELAY_W-1:0] lim);
      sodt_reached = ({1'b0, cnt} + 1'b1) >= {1'b0, lim};
   endfunction

   sodt_pkg::sodt_cfg_s cfg_q;
   sodt_pkg::sodt_cfg_s cfg_d;
   sodt_pkg::sodt_state_e state_q;
   sodt_pkg::sodt_state_e state_d;
   sodt_pkg::sodt_status_s status_q;
   logic [DELAY_W-1:0] cnt_q;
   logic [DELAY_W-1:0] cnt_d;
   logic link_q;
   logic fault_q;
   logic fault_d;
   logic [CW-1:0] clr_cnt_q;

   wire link_rise = logic_link_input_i && !link_q;
   wire is_nrt = (cfg_q.mode == sodt_pkg::SODT_MODE_OFF_NRT);
   wire is_rt = (cfg_q.mode == sodt_pkg::SODT_MODE_OFF_RT);
   wire is_on_dly = (cfg_q.mode == sodt_pkg::SODT_MODE_ON_DLY);
   wire expired = sodt_reached(cnt_q, cfg_q.delay);
   wire off_run = (state_q == sodt_pkg::SODT_ST_OFF_RUN);
   wire off_expire = off_run && expired && !(is_rt && logic_link_input_i);
   wire fault_set = off_run && is_nrt && link_rise;
   wire fault_clr_expire = off_expire && !logic_link_input_i;
   wire clr_wait_run = fault_q && !off_run && !logic_link_input_i;
   wire clr_wait_done = clr_wait_run && (clr_cnt_q == CW'(FAULT_CLR_CYC - 1));
   wire outputs_d = (state_d == sodt_pkg::SODT_ST_ON) || (state_d == sodt_pkg::SODT_ST_OFF_RUN);
   wire timing_d = (state_d == sodt_pkg::SODT_ST_OFF_RUN) || (state_d == sodt_pkg::SODT_ST_ON_RUN);

   // Strap sampled only on the configuration strobe
   always_comb begin
      cfg_d = cfg_q;
      if (config_i) begin
         cfg_d.valid = 1'b1;
         cfg_d.delay = delay_setting_i;
         if (mode_select_input_i) begin
            cfg_d.mode = sodt_pkg::SODT_MODE_OFF_RT;
         end else if (on_delay_select_i) begin
            cfg_d.mode = sodt_pkg::SODT_MODE_ON_DLY;
         end else begin
            cfg_d.mode = sodt_pkg::SODT_MODE_OFF_NRT;
         end
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         sodt_pkg::SODT_ST_IDLE: begin
            cnt_d = '0;
            // A fresh rise is needed, so expiry with the link held high stays off
            if (cfg_q.valid && link_rise) begin
               state_d = is_on_dly ? sodt_pkg::SODT_ST_ON_RUN : sodt_pkg::SODT_ST_ON;
            end
         end
         sodt_pkg::SODT_ST_ON: begin
            cnt_d = '0;
            if (!logic_link_input_i) begin
               state_d = is_on_dly ? sodt_pkg::SODT_ST_IDLE : sodt_pkg::SODT_ST_OFF_RUN;
            end
         end
         sodt_pkg::SODT_ST_OFF_RUN: begin
            cnt_d = cnt_q + 1'b1;
            if (is_rt && logic_link_input_i) begin
               state_d = sodt_pkg::SODT_ST_ON;
               cnt_d = '0;
            end else if (expired) begin
               state_d = sodt_pkg::SODT_ST_IDLE;
            end
         end
         sodt_pkg::SODT_ST_ON_RUN: begin
            cnt_d = cnt_q + 1'b1;
            if (!logic_link_input_i) begin
               state_d = sodt_pkg::SODT_ST_IDLE;
               cnt_d = '0;
            end else if (expired) begin
               state_d = sodt_pkg::SODT_ST_ON;
            end
         end
         default: begin
            state_d = sodt_pkg::SODT_ST_IDLE;
            cnt_d = '0;
         end
      endcase
      if (config_i) begin
         state_d = sodt_pkg::SODT_ST_IDLE;
         cnt_d = '0;
      end
   end

   // Set has priority over all three clear paths (expiry, wait done, config)
   always_comb begin
      fault_d = fault_q;
      if (fault_set) begin
         fault_d = 1'b1;
      end else if (fault_clr_expire || clr_wait_done || config_i) begin
         fault_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= '{mode: sodt_pkg::SODT_MODE_OFF_NRT, delay: sodt_pkg::DELAY_RST, valid: 1'b0};
         state_q <= sodt_pkg::SODT_ST_IDLE;
         cnt_q <= '0;
         link_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         link_q <= logic_link_input_i;
         fault_q <= fault_d;
      end
   end

   // Delay before auto-clear once the link is low again
   always_ff @(posedge clk_i) begin
      if (rst_i || !clr_wait_run || clr_wait_done) begin
         clr_cnt_q <= '0;
      end else begin
         clr_cnt_q <= clr_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= '0;
      end else begin
         status_q.outputs_on <= outputs_d;
         status_q.timing <= timing_d;
         status_q.fault <= fault_d;
      end
   end

   assign safety_out_o = status_q.outputs_on;
   assign timing_o = status_q.timing;
   assign fault_o = status_q.fault;
   assign configured_o = cfg_q.valid;
   assign mode_o = cfg_q.mode;

   sodt_indicator #(
      .FLASH_HALF_CYC(FLASH_HALF_CYC),
      .RED_HALF_CYC(RED_HALF_CYC),
      .RED_FLASHES(sodt_pkg::RED_FLASHES),
      .RED_PAUSE_SLOTS(sodt_pkg::RED_PAUSE_SLOTS)
   ) u_indicator (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .link_i(link_q),
      .status_i(status_q),
      .logic_in_led_o(logic_in_led_o),
      .green_o(power_fault_green_o),
      .red_o(power_fault_red_o)
   );
endmodule // sodt_timer

//--- tb/sodt_link_src.sv
`timescale 1ns/10ps
module sodt_link_src (
   input wire logic clk_i,
   output logic link_o
);
   initial link_o = 1'b0;
   // Level changes just after an edge, then holds n edges
   task automatic drive(input logic lv, input int n);
      @(posedge clk_i);
      #1 link_o = lv;
      repeat (n) @(posedge clk_i);
      #2;
   endtask
endmodule // sodt_link_src

//--- tb/sodt_checker_properties.sv
`timescale 1ns/10ps
module sodt_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic logic_link_input_i,
   input wire logic config_i,
   input wire logic [sodt_pkg::DELAY_W-1:0] delay_setting_i,
   input wire logic safety_out_o,
   input wire logic timing_o,
   input wire logic fault_o,
   input wire sodt_pkg::sodt_mode_e mode_o,
   input wire logic power_fault_green_o,
   input wire logic power_fault_red_o
);
   logic [31:0] dly_q;
   logic [31:0] cnt_q;
   wire logic lnk = logic_link_input_i;
   wire logic nrt = mode_o == sodt_pkg::SODT_MODE_OFF_NRT;
   wire logic rt = mode_o == sodt_pkg::SODT_MODE_OFF_RT;
   wire logic ond = mode_o == sodt_pkg::SODT_MODE_ON_DLY;
   // Own copy of the latched delay and length of the current timing run
   always_ff @(posedge clk_i) begin
      dly_q <= rst_i ? 32'h0000_0001 : (config_i ? 32'(delay_setting_i) : dly_q);
      cnt_q <= timing_o ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_link_on: assert property (!ond && !timing_o && !config_i && $rose(lnk) |-> ##[1:3] safety_out_o)
      else $error("link rise gave no output");
   a_fault_set: assert property (nrt && timing_o && $rose(lnk) |-> ##[1:2] fault_o)
      else $error("no fault on reassert");
   a_full_run: assert property (nrt && $fell(timing_o) && !$past(config_i) |-> !safety_out_o && cnt_q + 2 >= dly_q)
      else $error("off-delay cut short");
   a_time_bound: assert property (timing_o |-> cnt_q <= dly_q + 32'h0000_0002)
      else $error("timer overran delay");
   a_rt_retrig: assert property (rt && timing_o && $rose(lnk) |-> safety_out_o [*3] ##0 !timing_o && !fault_o)
      else $error("retrigger failed");
   a_rt_clean: assert property (rt && $past(rt) |-> !fault_o)
      else $error("fault in retriggerable mode");
   a_ond_wait: assert property (ond && timing_o |-> !safety_out_o)
      else $error("output on before delay");
   a_ond_drop: assert property (ond && $fell(lnk) |-> ##2 !safety_out_o && !fault_o)
      else $error("on-delay output stayed on");
   a_exp_clear: assert property (nrt && $fell(timing_o) && !lnk && !$past(lnk, 2) |-> ##[0:1] !fault_o)
      else $error("fault kept after expiry");
   a_red_idle: assert property (!fault_o [*4] |-> !power_fault_red_o)
      else $error("red lit without fault");
   a_green_on: assert property (!$past(rst_i) |-> power_fault_green_o)
      else $error("green not steady");
   a_mode_hold: assert property (!$past(config_i) |-> $stable(mode_o))
      else $error("mode changed without config");
   c_nrt_fault: cover property (timing_o && fault_o);
   c_rt_retrig: cover property (rt && $fell(timing_o) && safety_out_o);
   c_ond_on: cover property (ond && $rose(safety_out_o));
endmodule // sodt_checker
bind sodt_timer sodt_checker sodt_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .logic_link_input_i(logic_link_input_i),
   .config_i(config_i), .delay_setting_i(delay_setting_i), .safety_out_o(safety_out_o), .timing_o(timing_o),
   .fault_o(fault_o), .mode_o(mode_o), .power_fault_green_o(power_fault_green_o), .power_fault_red_o(power_fault_red_o));

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam int unsigned FC = 8;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic link;
   logic strap = 1'b0;
   logic ondly = 1'b0;
   logic cfg = 1'b0;
   logic [31:0] dly = 32'h0000_0010;
   logic safe, tmg, flt, cfgd, led, grn, red;
   sodt_pkg::sodt_mode_e mode;
   int fail_count = 0;
   int checked = 0;
   int d;
   logic [31:0] lfsr = 32'hBB84ED0B;
   always #12.5 clk_i = ~clk_i;
   sodt_link_src sodt_link_src_inst (.clk_i(clk_i), .link_o(link));
   sodt_timer #(.FAULT_CLR_CYC(FC), .FLASH_HALF_CYC(4), .RED_HALF_CYC(3)) sodt_timer_inst (
      .clk_i(clk_i), .rst_i(rst_i), .logic_link_input_i(link), .mode_select_input_i(strap),
      .on_delay_select_i(ondly), .config_i(cfg), .delay_setting_i(dly), .safety_out_o(safe),
      .timing_o(tmg), .fault_o(flt), .configured_o(cfgd), .mode_o(mode), .logic_in_led_o(led),
      .power_fault_green_o(grn), .power_fault_red_o(red));
   task automatic chk(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic chkm(input sodt_pkg::sodt_mode_e e);
      checked++;
      if (mode !== e) begin
         fail_count++;
         $display("BAD mode exp %h got %h", e, mode);
      end
   endtask
   task automatic go(input logic lv, input int n);
      sodt_link_src_inst.drive(lv, n);
   endtask
   // Latch a random delay, then scramble the straps to show they are ignored
   task automatic setup(input logic s, input logic o);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      d = 16 + int'(lfsr[2:0]);
      @(posedge clk_i);
      #1 strap = s;
      ondly = o;
      dly = 32'(d);
      cfg = 1'b1;
      @(posedge clk_i);
      #1 cfg = 1'b0;
      strap = lfsr[5];
      ondly = lfsr[6];
   endtask
   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #(25 * 4000);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      #1 rst_i = 1'b0;
      setup(1'b0, 1'b0);
      chkm(sodt_pkg::SODT_MODE_OFF_NRT);
      chk("configured", 1'b1, cfgd);
      go(1'b1, 3);
      chk("safe", 1'b1, safe);
      go(1'b0, 3);
      chk("timing", 1'b1, tmg);
      chk("led", 1'b1, led);
      go(1'b1, 3);
      chk("fault", 1'b1, flt);
      chk("red", 1'b1, red);
      chk("safe", 1'b1, safe);
      go(1'b1, d - 4);
      chk("safe", 1'b0, safe);
      go(1'b0, 4);
      chk("fault", 1'b1, flt);
      go(1'b0, FC + 2);
      chk("fault", 1'b0, flt);
      chk("green", 1'b1, grn);
      chk("red", 1'b0, red);
      $display("test nrt_retrig done");
      setup(1'b0, 1'b0);
      go(1'b1, 3);
      go(1'b0, 3);
      go(1'b1, 3);
      go(1'b0, 3);
      chk("fault", 1'b1, flt);
      chk("safe", 1'b1, safe);
      go(1'b0, d - 8);
      chk("safe", 1'b0, safe);
      chk("fault", 1'b0, flt);
      $display("test nrt_double done");
      setup(1'b1, 1'b0);
      chkm(sodt_pkg::SODT_MODE_OFF_RT);
      go(1'b1, 3);
      go(1'b0, 3);
      chk("timing", 1'b1, tmg);
      go(1'b1, 3);
      chk("timing", 1'b0, tmg);
      chk("fault", 1'b0, flt);
      go(1'b1, d);
      go(1'b0, d - 4);
      chk("safe", 1'b1, safe);
      go(1'b0, 7);
      chk("safe", 1'b0, safe);
      $display("test rt done");
      setup(1'b0, 1'b1);
      chkm(sodt_pkg::SODT_MODE_ON_DLY);
      go(1'b1, d - 4);
      chk("safe", 1'b0, safe);
      chk("timing", 1'b1, tmg);
      go(1'b0, 2);
      chk("safe", 1'b0, safe);
      chk("timing", 1'b0, tmg);
      chk("fault", 1'b0, flt);
      go(1'b1, d - 4);
      chk("safe", 1'b0, safe);
      go(1'b1, 7);
      chk("safe", 1'b1, safe);
      go(1'b0, 2);
      chk("safe", 1'b0, safe);
      $display("test on_delay done");
      end_of_test();
   end
endmodule // tb_top
